/* hw/spo_top.sv */
/*
   Stepped pulse output generator with an AXI4-Lite register slave.
   Drives one bit of one of sixteen output words with a 50% square wave.
   Assumes one write and one read outstanding at most, single clock aclk.
*/
`timescale 1ns/1ps
module spo_top
   import spo_pkg::*;
#(
   parameter logic [21:0] RATE_NUM = SPO_HALF_NUM
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output      logic [3:0]  pulse_word_index,
   output      logic [15:0] pulse_bit_mask,
   output      logic [15:0] pulse_bit_value,
   output      logic        pulse_active_flag_first,
   output      logic        pulse_active_flag_second
);
   // Bus slave state
   logic        aw_got_q, w_got_q, awready_q, wready_q, bvalid_q;
   logic        aw_got_d, w_got_d, bvalid_d;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic [1:0]  bresp_q;
   logic        arready_q, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rd_data;
   logic [1:0]  rresp_q;
   logic        rd_ok, do_wr, wr_map, wr_full, ar_take;

   // Registers and command pulses
   logic [15:0] word_sel_q, count_lo_q, count_hi_q;
   logic [31:0] start_op_q;
   logic        start_pulse_q, stop_pulse_q, refused_q;
   logic [23:0] preset_q;
   logic        preset_ok_q;

   // Generator state
   spo_state_t  state_q;
   logic        level_q;
   logic [21:0] cnt_q, half_q;
   logic [23:0] remain_q;
   logic        indep_q;
   logic [3:0]  bit_q, word_q;

   // Converted operands
   logic [31:0] count_bin;
   logic [15:0] freq_bin;
   logic [7:0]  bit_bin, word_bin;
   logic        count_dig_ok, freq_dig_ok, bit_dig_ok, word_dig_ok;
   logic        count_ok, freq_ok, bit_ok, word_ok, mode_ok, freq_zero;
   logic        need_preset, cmd_ok, start_run, stop_all;
   logic        div_start, div_done, toggle, fall, last;
   logic [21:0] div_quot;
   logic [3:0]  mode_dig;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction : merge16

   // Write channel bookkeeping; address and data taken in either order
   assign do_wr    = aw_got_q & w_got_q & ~bvalid_q;
   assign aw_got_d = (aw_got_q & ~do_wr) | (s_axi_awvalid & awready_q);
   assign w_got_d  = (w_got_q & ~do_wr) | (s_axi_wvalid & wready_q);
   assign bvalid_d = (bvalid_q & ~s_axi_bready) | do_wr;
   assign wr_map   = (aw_addr_q[7:5] == 3'b000) && (aw_addr_q[1:0] == 2'b00);
   assign wr_full  = (w_strb_q == 4'hF);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= SPO_RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
      end else begin
         aw_got_q  <= aw_got_d;
         w_got_q   <= w_got_d;
         awready_q <= ~aw_got_d & ~bvalid_d;
         wready_q  <= ~w_got_d & ~bvalid_d;
         bvalid_q  <= bvalid_d;
         if (do_wr) bresp_q <= wr_map ? SPO_RESP_OKAY : SPO_RESP_SLVERR;
         if (s_axi_awvalid & awready_q) aw_addr_q <= s_axi_awaddr;
         if (s_axi_wvalid & wready_q) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
      end
   end

   // Software registers; commands need all four byte lanes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_sel_q    <= SPO_WORD_SEL_RST;
         count_lo_q    <= SPO_COUNT_RST;
         count_hi_q    <= SPO_COUNT_RST;
         start_op_q    <= '0;
         start_pulse_q <= 1'b0;
         stop_pulse_q  <= 1'b0;
      end else begin
         start_pulse_q <= do_wr && aw_addr_q == SPO_OFS_START && wr_full;
         stop_pulse_q  <= do_wr && aw_addr_q == SPO_OFS_CONTROL && wr_full &&
                          w_data_q[11:0] == SPO_CTRL_STOP;
         if (do_wr && aw_addr_q == SPO_OFS_WORD_SEL)
            word_sel_q <= merge16(word_sel_q, w_data_q, w_strb_q);
         if (do_wr && aw_addr_q == SPO_OFS_COUNT_LO)
            count_lo_q <= merge16(count_lo_q, w_data_q, w_strb_q);
         if (do_wr && aw_addr_q == SPO_OFS_COUNT_HI)
            count_hi_q <= merge16(count_hi_q, w_data_q, w_strb_q);
         if (do_wr && aw_addr_q == SPO_OFS_START && wr_full)
            start_op_q <= w_data_q;
      end
   end

   // Operand conversion and range checks
   spo_bcd2bin #(.DIGITS(8)) u_count_conv (
      .bcd ({count_hi_q, count_lo_q}),
      .bin (count_bin),
      .ok  (count_dig_ok)
   );
   spo_bcd2bin #(.DIGITS(4)) u_freq_conv (
      .bcd (start_op_q[SPO_START_FREQ_LSB +: 16]),
      .bin (freq_bin),
      .ok  (freq_dig_ok)
   );
   spo_bcd2bin #(.DIGITS(2)) u_bit_conv (
      .bcd (start_op_q[SPO_START_BIT_LSB+4 +: 8]),
      .bin (bit_bin),
      .ok  (bit_dig_ok)
   );
   spo_bcd2bin #(.DIGITS(2)) u_word_conv (
      .bcd (word_sel_q[7:0]),
      .bin (word_bin),
      .ok  (word_dig_ok)
   );

   assign mode_dig  = start_op_q[SPO_START_MODE_LSB +: 4];
   assign count_ok  = count_dig_ok && count_bin != '0 && count_bin <= SPO_COUNT_MAX;
   assign freq_zero = (freq_bin == '0);
   assign freq_ok   = freq_dig_ok &&
                      (freq_zero || (freq_bin >= SPO_FREQ_MIN && freq_bin <= SPO_FREQ_MAX));
   assign bit_ok    = bit_dig_ok && bit_bin <= SPO_INDEX_MAX &&
                      start_op_q[SPO_START_BIT_LSB +: 4] == 4'h0;
   assign word_ok   = word_dig_ok && word_bin <= SPO_INDEX_MAX &&
                      word_sel_q[15:8] == 8'h00;
   assign mode_ok   = (mode_dig == SPO_MODE_INDEP) || (mode_dig == SPO_MODE_CONT);
   // An independent start from idle needs a loaded count to run against
   assign need_preset = (state_q == SPO_IDLE) && mode_dig == SPO_MODE_INDEP &&
                        ~freq_zero && ~preset_ok_q;
   assign cmd_ok    = freq_ok & bit_ok & mode_ok & word_ok & ~need_preset;
   assign start_run = start_pulse_q & cmd_ok & ~freq_zero & ~stop_pulse_q;
   assign stop_all  = stop_pulse_q | (start_pulse_q & cmd_ok & freq_zero);
   assign div_start = start_run;

   // Count load and refusal flag; bad operands are simply not acted upon
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         preset_q    <= '0;
         preset_ok_q <= 1'b0;
         refused_q   <= 1'b0;
      end else begin
         if (do_wr && aw_addr_q == SPO_OFS_COUNT_LOAD && wr_full) begin
            if (count_ok) begin
               preset_q    <= count_bin[23:0];
               preset_ok_q <= 1'b1;
            end
            refused_q <= ~count_ok;
         end else if (start_pulse_q) begin
            refused_q <= ~cmd_ok;
         end
      end
   end

   // Half period in cycles from the frequency operand
   spo_divider u_rate_div (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .start    (div_start),
      .dividend (RATE_NUM),
      .divisor  (freq_bin[6:0]),
      .done     (div_done),
      .quotient (div_quot)
   );

   assign toggle = (state_q == SPO_RUN || state_q == SPO_RECALC) &&
                   (cnt_q >= half_q - 22'd1);
   assign fall   = toggle & level_q;
   assign last   = fall & indep_q & (remain_q == 24'd1);

   // Sequencer: a change while running only recomputes the rate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= SPO_IDLE;
      end else if (stop_all | last) begin
         state_q <= SPO_IDLE;
      end else begin
         unique case (state_q)
            SPO_IDLE:   if (start_run) state_q <= SPO_CALC;
            SPO_CALC:   if (div_done & ~start_run) state_q <= SPO_RUN;
            SPO_RUN:    if (start_run) state_q <= SPO_RECALC;
            SPO_RECALC: if (div_done & ~start_run) state_q <= SPO_RUN;
         endcase
      end
   end

   // Half-period counter and output level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= 1'b0;
         cnt_q   <= '0;
         half_q  <= RATE_NUM;
      end else if (stop_all || last || state_q == SPO_IDLE) begin
         level_q <= 1'b0;
         cnt_q   <= '0;
      end else if (state_q == SPO_CALC) begin
         if (div_done & ~start_run) begin
            half_q  <= div_quot;
            cnt_q   <= '0;
            level_q <= 1'b1;
         end
      end else begin
         // New rate applies to the half period already under way, no ramp
         if (state_q == SPO_RECALC && div_done && !start_run)
            half_q <= div_quot;
         if (toggle) begin
            cnt_q   <= '0;
            level_q <= ~level_q;
         end else begin
            cnt_q <= cnt_q + 22'd1;
         end
      end
   end

   // Target bit, word and mode are frozen at the start from idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_q    <= '0;
         word_q   <= '0;
         indep_q  <= 1'b0;
         remain_q <= '0;
      end else if (state_q == SPO_IDLE && start_run) begin
         bit_q    <= bit_bin[3:0];
         word_q   <= word_bin[3:0];
         indep_q  <= (mode_dig == SPO_MODE_INDEP);
         remain_q <= preset_q;
      end else if (fall & indep_q) begin
         remain_q <= remain_q - 24'd1;
      end
   end

   // Pin-side outputs; only the chosen bit is ever marked as driven
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_word_index         <= '0;
         pulse_bit_mask           <= '0;
         pulse_bit_value          <= '0;
         pulse_active_flag_first  <= 1'b0;
         pulse_active_flag_second <= 1'b0;
      end else begin
         pulse_word_index         <= word_q;
         pulse_bit_mask           <= (state_q != SPO_IDLE) ? (16'h0001 << bit_q) : 16'h0000;
         pulse_bit_value          <= level_q ? (16'h0001 << bit_q) : 16'h0000;
         pulse_active_flag_first  <= (state_q != SPO_IDLE);
         pulse_active_flag_second <= (state_q != SPO_IDLE);
      end
   end

   // Read decode
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      unique case (s_axi_araddr)
         SPO_OFS_WORD_SEL:   rd_data = {16'h0000, word_sel_q};
         SPO_OFS_COUNT_LO:   rd_data = {16'h0000, count_lo_q};
         SPO_OFS_COUNT_HI:   rd_data = {16'h0000, count_hi_q};
         SPO_OFS_COUNT_LOAD: rd_data = 32'h0000_0000;
         SPO_OFS_START:      rd_data = start_op_q;
         SPO_OFS_CONTROL:    rd_data = 32'h0000_0000;
         SPO_OFS_STATUS: begin
            rd_data[SPO_ST_ACTIVE]             = (state_q != SPO_IDLE);
            rd_data[SPO_ST_REFUSED]            = refused_q;
            rd_data[SPO_ST_LEVEL]              = level_q;
            rd_data[SPO_ST_PRESET_OK]          = preset_ok_q;
            rd_data[SPO_ST_WORD_LSB +: 4]      = word_q;
            rd_data[SPO_ST_BIT_LSB +: 4]       = bit_q;
         end
         SPO_OFS_REMAIN:     rd_data = {8'h00, remain_q};
         default:            rd_ok   = 1'b0;
      endcase
   end

   // Read channel: one outstanding, data held until taken
   assign ar_take  = s_axi_arvalid & arready_q;
   assign rvalid_d = (rvalid_q & ~s_axi_rready) | ar_take;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= SPO_RESP_OKAY;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q  <= rvalid_d;
         if (ar_take) begin
            rdata_q <= rd_data;
            rresp_q <= rd_ok ? SPO_RESP_OKAY : SPO_RESP_SLVERR;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

endmodule : spo_top

/* hw/spo_pkg.sv */
/*
   Constants of the stepped pulse output block: register offsets, field
   positions, operand codes, reset values and the rate arithmetic.
   Assumes a 50 MHz bus clock and a 32-bit AXI4-Lite register bus.
*/
// Behaviour
// - The output is a square wave whose high and low halves last equally long.
// - The frequency operand is BCD 0002 to 0100 in 10 Hz units, 20 Hz to 1 kHz.
// - Only one bit of the chosen word carries pulses; the other bits stay untouched.
// - The word select holds BCD 0000 to 0015, words 100 to 115, default word 100.
// - The bit operand holds the bit number 00 to 15 in its upper two BCD digits.
// - Mode 001 outputs pulses continuously until a stop arrives.
// - Mode 000 outputs exactly the preset count of pulses and then stops.
// - The count is eight BCD digits over two words, low word first, 1 to 16777215.
// - The preset count is captured at an independent start and later loads do not touch it.
// - A start with frequency 0, or the control code 003, stops the output.
// - An in-progress flag is shown; stops are meant to be issued only while it is set.
// - In preset mode a stop or a zero-frequency start ends output before the count.
// - A new frequency takes effect as an immediate step with no ramp.
package spo_pkg;

   // Register byte offsets
   localparam logic [7:0] SPO_OFS_WORD_SEL   = 8'h00;
   localparam logic [7:0] SPO_OFS_COUNT_LO   = 8'h04;
   localparam logic [7:0] SPO_OFS_COUNT_HI   = 8'h08;
   localparam logic [7:0] SPO_OFS_COUNT_LOAD = 8'h0C;
   localparam logic [7:0] SPO_OFS_START      = 8'h10;
   localparam logic [7:0] SPO_OFS_CONTROL    = 8'h14;
   localparam logic [7:0] SPO_OFS_STATUS     = 8'h18;
   localparam logic [7:0] SPO_OFS_REMAIN     = 8'h1C;

   // Reset values
   localparam logic [15:0] SPO_WORD_SEL_RST = 16'h0000;
   localparam logic [15:0] SPO_COUNT_RST    = 16'h0000;

   // Start command field positions
   localparam int SPO_START_FREQ_LSB = 0;
   localparam int SPO_START_BIT_LSB  = 16;
   localparam int SPO_START_MODE_LSB = 28;

   // Operand codes and ranges
   localparam logic [3:0]  SPO_MODE_INDEP    = 4'h0;
   localparam logic [3:0]  SPO_MODE_CONT     = 4'h1;
   localparam logic [11:0] SPO_CTRL_STOP     = 12'h003;
   localparam logic [15:0] SPO_FREQ_MIN      = 16'h0002;
   localparam logic [15:0] SPO_FREQ_MAX      = 16'h0064;
   localparam logic [7:0]  SPO_INDEX_MAX     = 8'h0F;
   localparam logic [31:0] SPO_COUNT_MAX     = 32'h00FF_FFFF;

   // Status bit positions
   localparam int SPO_ST_ACTIVE    = 0;
   localparam int SPO_ST_REFUSED   = 1;
   localparam int SPO_ST_LEVEL     = 2;
   localparam int SPO_ST_PRESET_OK = 3;
   localparam int SPO_ST_WORD_LSB  = 8;
   localparam int SPO_ST_BIT_LSB   = 12;

   // AXI responses
   localparam logic [1:0] SPO_RESP_OKAY   = 2'b00;
   localparam logic [1:0] SPO_RESP_SLVERR = 2'b10;

   // Rate: half period in cycles = clock / (2 * 10 Hz * F)
   localparam int unsigned SPO_CLK_HZ       = 50_000_000;
   localparam int unsigned SPO_FREQ_UNIT_HZ = 10;
   localparam int unsigned SPO_HALF_NUM_INT = SPO_CLK_HZ / (2 * SPO_FREQ_UNIT_HZ);
   localparam logic [21:0] SPO_HALF_NUM     = 22'(SPO_HALF_NUM_INT);
   localparam logic [4:0]  SPO_DIV_STEPS    = 5'd22;

   typedef enum logic [1:0] {
      SPO_IDLE   = 2'b00,
      SPO_CALC   = 2'b01,
      SPO_RUN    = 2'b11,
      SPO_RECALC = 2'b10
   } spo_state_t;

endpackage : spo_pkg

/* hw/spo_bcd2bin.sv */
/*
   Combinational BCD to binary converter with digit check.
   Assumes the caller registers the result where timing matters.
*/
`timescale 1ns/1ps
module spo_bcd2bin #(
   parameter int DIGITS = 4
) (
   input  wire logic [4*DIGITS-1:0] bcd,
   output      logic [4*DIGITS-1:0] bin,
   output      logic                ok
);
   localparam int W = 4 * DIGITS;

   logic [W-1:0] acc [DIGITS+1];
   logic [DIGITS-1:0] dig_ok;

   assign acc[0] = '0;

   // Horner sum from the top digit down
   genvar i;
   generate
      for (i = 0; i < DIGITS; i++) begin : g_digit
         logic [3:0] d;
         assign d = bcd[4*(DIGITS-1-i) +: 4];
         assign dig_ok[i] = (d <= 4'h9);
         assign acc[i+1] = W'(acc[i] * 10) + W'(d);
      end
   endgenerate

   assign bin = acc[DIGITS];
   assign ok  = &dig_ok;

endmodule : spo_bcd2bin

/* hw/spo_divider.sv */
/*
   Sequential restoring divider: quotient = dividend / divisor.
   One quotient bit per clock, 22 clocks; a new start restarts it.
   Assumes divisor is nonzero and below 128.
*/
`timescale 1ns/1ps
module spo_divider
   import spo_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        start,
   input  wire logic [21:0] dividend,
   input  wire logic [6:0]  divisor,
   output      logic        done,
   output      logic [21:0] quotient
);
   logic [21:0] sh_q;
   logic [6:0]  rem_q;
   logic [6:0]  div_q;
   logic [4:0]  steps_q;
   logic        busy_q;
   logic        done_q;
   logic [7:0]  trial;
   logic        fits;

   assign trial = {rem_q, sh_q[21]};
   assign fits  = (trial >= {1'b0, div_q});

   // Shift out one dividend bit, shift in one quotient bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh_q    <= '0;
         rem_q   <= '0;
         div_q   <= 7'h01;
         steps_q <= '0;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
      end else if (start) begin
         sh_q    <= dividend;
         rem_q   <= '0;
         div_q   <= divisor;
         steps_q <= SPO_DIV_STEPS;
         busy_q  <= 1'b1;
         done_q  <= 1'b0;
      end else if (busy_q) begin
         rem_q   <= fits ? 7'(trial - {1'b0, div_q}) : trial[6:0];
         sh_q    <= {sh_q[20:0], fits};
         steps_q <= steps_q - 5'd1;
         busy_q  <= (steps_q != 5'd1);
         done_q  <= (steps_q == 5'd1);
      end else begin
         done_q  <= 1'b0;
      end
   end

   assign done     = done_q;
   assign quotient = sh_q;

endmodule : spo_divider

/* tb/spo_top_properties.sv */
/*
   Port checker of the stepped pulse output block.
   Assumes it is bound to spo_top and sees only its ports.
*/
`timescale 1ns/1ps
module spo_top_properties (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [3:0]  pulse_word_index,
   input wire logic [15:0] pulse_bit_mask,
   input wire logic [15:0] pulse_bit_value,
   input wire logic        pulse_active_flag_first,
   input wire logic        pulse_active_flag_second
);
   // All checks on the bus clock, idle in reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   one_bit_a: assert property ($onehot0(pulse_bit_mask))
      else $error("more than one bit driven");
   value_in_mask_a: assert property ((pulse_bit_value & ~pulse_bit_mask) == 16'h0000)
      else $error("pulse outside driven bit");
   flags_equal_a: assert property (pulse_active_flag_first == pulse_active_flag_second)
      else $error("active flags differ");
   mask_needs_flag_a: assert property (pulse_bit_mask != 16'h0000
      |-> pulse_active_flag_first)
      else $error("bit driven while idle");
   idle_low_a: assert property (!pulse_active_flag_first |-> pulse_bit_value == 16'h0000)
      else $error("level high while idle");
   word_held_a: assert property (pulse_active_flag_first
      && $past(pulse_active_flag_first) |-> $stable(pulse_word_index))
      else $error("word changed while active");
   // Both channels taken together: registered join, then registered answer
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   resp_held_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response dropped");
   rdata_held_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule : spo_top_properties

bind spo_top spo_top_properties u_props (.*);

/* tb/spo_load_model.sv */
/*
   Transistor output stage with load: merges the pulse bit into the word and
   measures high and low halves and finished pulses.
   Assumes the pulse outputs change only at aclk edges.
*/
`timescale 1ns/1ps
module spo_load_model (
   input  wire logic        aclk,
   input  wire logic [15:0] word_base,
   input  wire logic [15:0] pulse_bit_mask,
   input  wire logic [15:0] pulse_bit_value,
   output      logic [15:0] load_level,
   output      int          pulses,
   output      int          high_len,
   output      int          low_len
);
   logic lvl_q = 1'b0;
   int   run   = 0;
   int   npulse = 0;
   // Undriven bits keep the program's own value
   assign load_level = (word_base & ~pulse_bit_mask) | (pulse_bit_value & pulse_bit_mask);
   assign pulses = npulse;
   // Run length of each level, pulse counted at its falling edge
   always @(posedge aclk) begin
      lvl_q <= |pulse_bit_value;
      if ((|pulse_bit_value) != lvl_q) begin
         run <= 1;
         if (lvl_q) begin
            high_len <= run;
            npulse   <= npulse + 1;
         end else begin
            low_len <= run;
         end
      end else begin
         run <= run + 1;
      end
   end
endmodule : spo_load_model

/* tb/test_stepped_pulse_output.sv */
/*
   Self-checking bench of the stepped pulse output block over AXI4-Lite.
   Assumes RATE_NUM 2500, so the half period is 2500 / F cycles.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module test_stepped_pulse_output;
   import spo_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdat;
   logic [1:0]  resp;
   logic        awrdy, wrdy, bvld, arrdy, rvld, fl1, fl2;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [3:0]  widx;
   logic [15:0] mask, value, load;
   int err_count = 0, num_checks = 0, cyc = 0, pulses, hlen, llen, p0;
   spo_top #(.RATE_NUM(22'd2500)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rready),
      .pulse_word_index(widx), .pulse_bit_mask(mask), .pulse_bit_value(value),
      .pulse_active_flag_first(fl1), .pulse_active_flag_second(fl2));
   spo_load_model u_load (.aclk(aclk), .word_base(16'hA5A5), .pulse_bit_mask(mask),
      .pulse_bit_value(value), .load_level(load), .pulses(pulses), .high_len(hlen),
      .low_len(llen));
   // 50 MHz clock; hang guard well above the longest scenario
   always #10 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // Write: both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
      // Late bready lets the held-response checks see a stalled answer
      do begin
         @(posedge aclk);
         if (awrdy && awvalid) awvalid <= 0;
         if (wrdy && wvalid) wvalid <= 0;
         if (bvld && !bready) bready <= 1;
      end while (!(bvld && bready));
      resp = bresp; bready <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1;
      do begin
         @(posedge aclk);
         if (arrdy && arvalid) arvalid <= 0;
         if (rvld && !rready) rready <= 1;
      end while (!(rvld && rready));
      rdat = rdata; resp = rresp; rready <= 0;
   endtask : rd
   task automatic wait_flag(input logic v, input int n);
      repeat (n) if (fl1 !== v) @(posedge aclk);
   endtask : wait_flag
   task automatic t_regs();
      rd(SPO_OFS_WORD_SEL);
      `CHK("word_sel reset", 32'h0, rdat)
      rd(8'h20);
      `CHK("unmapped resp", SPO_RESP_SLVERR, resp)
      wr(SPO_OFS_WORD_SEL, 32'h0002);
      `CHK("write resp", SPO_RESP_OKAY, resp)
      wr(SPO_OFS_START, {4'h1, 12'h050, 16'h0101});
      rd(SPO_OFS_STATUS);
      `CHK("freq over range", 2'b10, rdat[1:0])
   endtask : t_regs
   task automatic t_indep();
      wr(SPO_OFS_COUNT_LO, 32'h0003);
      wr(SPO_OFS_COUNT_HI, 32'h0000);
      wr(SPO_OFS_COUNT_LOAD, 32'h0);
      wr(SPO_OFS_START, {4'h0, 12'h050, 16'h0100});
      wait_flag(1, 10);
      p0 = pulses;
      wr(SPO_OFS_COUNT_LO, 32'h0007);
      wr(SPO_OFS_COUNT_LOAD, 32'h0);
      `CHK("word", 4'h2, widx)
      `CHK("mask", 16'h0020, mask)
      `CHK("other bits", 16'hA585, load & 16'hFFDF)
      wait_flag(0, 400);
      @(posedge aclk);
      `CHK("pulse count", 3, pulses - p0)
      `CHK("high half", 25, hlen)
      `CHK("low half", 25, llen)
      `CHK("level after", 16'h0000, value)
   endtask : t_indep
   task automatic t_cont();
      wr(SPO_OFS_START, {4'h1, 12'h150, 16'h0002});
      wait_flag(1, 10);
      `CHK("mask", 16'h8000, mask)
      repeat (2600) @(posedge aclk);
      `CHK("slow half", 1250, hlen)
      wr(SPO_OFS_START, {4'h1, 12'h150, 16'h0050});
      repeat (200) @(posedge aclk);
      `CHK("stepped half", 50, hlen)
      `CHK("still running", 1'b1, fl1)
      wr(SPO_OFS_CONTROL, 32'h003);
      wait_flag(0, 5);
      `CHK("stopped", 1'b0, fl1)
      `CHK("mask cleared", 16'h0000, mask)
   endtask : t_cont
   task automatic t_zero();
      wr(SPO_OFS_COUNT_LO, 32'h7215);
      wr(SPO_OFS_COUNT_HI, 32'h1677);
      wr(SPO_OFS_COUNT_LOAD, 32'h0);
      wr(SPO_OFS_START, {4'h0, 12'h000, 16'h0100});
      wait_flag(1, 10);
      repeat (100) @(posedge aclk);
      `CHK("max count runs", 1'b1, fl1)
      wr(SPO_OFS_START, {4'h0, 12'h000, 16'h0000});
      wait_flag(0, 5);
      `CHK("zero freq stop", 1'b0, fl1)
   endtask : t_zero
   // Reset for five cycles, then the scenarios in turn
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      t_regs();
      t_indep();
      t_cont();
      t_zero();
      report_and_stop();
   end
endmodule : test_stepped_pulse_output
